// file: logic/cssc_defines.vh
// cssc_defines.vh: fuse codes, start-up counts and shipped fuse values
// for the clock source and start-up controller; definitions only
`ifndef CSSC_DEFINES_VH
`define CSSC_DEFINES_VH

// clock source select fuse codes (0 = programmed)
`define CSSC_SRC_EXT_CLK 4'h0
`define CSSC_SRC_RESERVED 4'h1
`define CSSC_SRC_CAL_RC 4'h2
`define CSSC_SRC_RC_128K 4'h3
`define CSSC_SRC_LF_XTAL_MIN 4'h4
`define CSSC_SRC_FS_XTAL_MIN 4'h6
`define CSSC_SRC_LP_XTAL_MIN 4'h8

// one-hot source class positions
`define CSSC_CLS_LP_XTAL 0
`define CSSC_CLS_FS_XTAL 1
`define CSSC_CLS_LF_XTAL 2
`define CSSC_CLS_RC_128K 3
`define CSSC_CLS_CAL_RC 4
`define CSSC_CLS_EXT_CLK 5
`define CSSC_CLS_RESERVED 6
`define CSSC_CLS_W 7

// time-out delay lengths in watchdog oscillator cycles
`define CSSC_TOUT_NONE 16'h0000
`define CSSC_TOUT_SHORT 16'h0200
`define CSSC_TOUT_LONG 16'h2000

// oscillator start-up lengths in selected oscillator cycles
`define CSSC_OSC_EXT 16'h0006
`define CSSC_OSC_258 16'h0102
`define CSSC_OSC_1K 16'h0400
`define CSSC_OSC_16K 16'h4000
`define CSSC_OSC_32K 16'h8000
`define CSSC_OSC_RESET_EXTRA 16'h000e

// system clock prescale when the divide-by-eight fuse is programmed
`define CSSC_DIV8_LAST 3'h7

// shipped fuse values
`define CSSC_SHIP_SRC 4'h2
`define CSSC_SHIP_SUT 2'h2
`define CSSC_SHIP_DIV8 1'b0

`endif

// file: logic/cssc_startup_ctrl.v
// cssc_startup_ctrl.v: clock source decode, start-up reset sequencing and
// clock domain gating, all on the single system clock clk.
// assumes oscillator cycles arrive as one-cycle tick pulses synchronous to
// clk, and that sleep control drives the domain run requests.
//
// What this block does
// - decode four source fuses into crystal, RC, external clock or reserved
// - a fuse bit at one is unprogrammed, at zero programmed
// - shipped fuses: calibrated RC, divide by eight, start-up 10, time-out on
// - hold internal reset for a time-out after other resets release
// - time-out counted in watchdog cycles, length chosen by fuses
// - time-out lengths are 0, 512 or 8192 watchdog cycles
// - time-out is a fixed count and never senses supply level
// - counter on selected oscillator holds reset for the start-up count
// - start-up count from 6 cycles external clock to 32K low-frequency crystal
// - start from reset applies time-out and oscillator start-up count
// - wake from power-save or power-down applies only the start-up count
// - selected source clock is routed to the module clock domains
// - unused domain clocks may be stopped by sleep modes
// - stopping the core domain halts core, register file and stack
// - peripheral domain clock runs timers, serial ports, interrupt unit
// - flash domain clock runs whenever the core domain clock runs
// - asynchronous timer domain keeps running during sleep
// - converter domain runs while core and peripheral clocks stop
// - source lsb and start-up fuses pick 258, 1K or 16K plus 14
// - programmed divide-by-eight fuse divides system clock by eight

`include "cssc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module cssc_startup_ctrl #(
    parameter CNT_W = 16
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // fuses, 0 = programmed
    input wire [3:0] clock_source_select_fuses,
    input wire [1:0] startup_delay_fuses,
    input wire divide_by_eight_fuse,
    // other reset sources and sleep wake-up
    input wire other_reset_active,
    input wire wake_from_sleep,
    // oscillator cycle ticks
    input wire wdt_osc_tick,
    input wire osc_tick,
    // domain run requests from sleep control, and the async oscillator tick
    input wire core_run_req,
    input wire io_run_req,
    input wire adc_run_req,
    input wire async_run_req,
    input wire async_osc_tick,
    // reset and status
    output reg internal_reset_n_reg,
    output reg startup_busy_reg,
    output reg [`CSSC_CLS_W-1:0] source_class_reg,
    // routed clock enables
    output reg system_clock_tick_reg,
    output reg core_domain_clock,
    output reg peripheral_domain_clock,
    output reg flash_domain_clock,
    output reg async_timer_clock,
    output reg converter_domain_clock
);

// ----------------------------------------------------------------
// decode functions
// ----------------------------------------------------------------
function [`CSSC_CLS_W-1:0] src_class;
    input [3:0] f;
    begin
        src_class = {`CSSC_CLS_W{1'b0}};
        if (f >= `CSSC_SRC_LP_XTAL_MIN) begin
            src_class[`CSSC_CLS_LP_XTAL] = 1'b1;
        end else if (f >= `CSSC_SRC_FS_XTAL_MIN) begin
            src_class[`CSSC_CLS_FS_XTAL] = 1'b1;
        end else if (f >= `CSSC_SRC_LF_XTAL_MIN) begin
            src_class[`CSSC_CLS_LF_XTAL] = 1'b1;
        end else if (f == `CSSC_SRC_RC_128K) begin
            src_class[`CSSC_CLS_RC_128K] = 1'b1;
        end else if (f == `CSSC_SRC_CAL_RC) begin
            src_class[`CSSC_CLS_CAL_RC] = 1'b1;
        end else if (f == `CSSC_SRC_EXT_CLK) begin
            src_class[`CSSC_CLS_EXT_CLK] = 1'b1;
        end else begin
            src_class[`CSSC_CLS_RESERVED] = 1'b1;
        end
    end
endfunction

function is_xtal;
    input [3:0] f;
    begin
        is_xtal = (f >= `CSSC_SRC_FS_XTAL_MIN);
    end
endfunction

// time-out length: a pure cycle count, no supply sensing
function [CNT_W-1:0] tout_len;
    input [3:0] f;
    input [1:0] sut;
    reg [2:0] key;
    begin
        key = {f[0], sut};
        tout_len = `CSSC_TOUT_LONG;
        if (is_xtal(f)) begin
            case (key)
                3'h0, 3'h3, 3'h6: tout_len = `CSSC_TOUT_SHORT;
                3'h2, 3'h5: tout_len = `CSSC_TOUT_NONE;
                default: tout_len = `CSSC_TOUT_LONG;
            endcase
        end else begin
            case (sut)
                2'h0: tout_len = `CSSC_TOUT_NONE;
                2'h1: tout_len = `CSSC_TOUT_SHORT;
                default: tout_len = `CSSC_TOUT_LONG;
            endcase
        end
    end
endfunction

// oscillator start-up length, without the extra cycles after reset
function [CNT_W-1:0] osc_len;
    input [3:0] f;
    input [1:0] sut;
    reg [2:0] key;
    begin
        key = {f[0], sut};
        osc_len = `CSSC_OSC_EXT;
        if (is_xtal(f)) begin
            case (key)
                3'h0, 3'h1: osc_len = `CSSC_OSC_258;
                3'h2, 3'h3, 3'h4: osc_len = `CSSC_OSC_1K;
                default: osc_len = `CSSC_OSC_16K;
            endcase
        end else if (f >= `CSSC_SRC_LF_XTAL_MIN) begin
            osc_len = `CSSC_OSC_32K;
        end else begin
            osc_len = `CSSC_OSC_EXT;
        end
    end
endfunction

// ----------------------------------------------------------------
// start-up sequencer
// ----------------------------------------------------------------
localparam [4:0] ST_LOAD = 5'h01;
localparam [4:0] ST_TOUT = 5'h02;
localparam [4:0] ST_OSC = 5'h04;
localparam [4:0] ST_RUN = 5'h08;
localparam [4:0] ST_WAKE = 5'h10;

reg [4:0] state_reg;
reg [3:0] src_fuse_reg;
reg [1:0] sut_fuse_reg;
reg div8_fuse_reg;
reg [CNT_W-1:0] cnt_reg;
reg [2:0] div_cnt_reg;

// fuses are latched while sequencing from reset, never under rstn
always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        src_fuse_reg <= `CSSC_SHIP_SRC;
        sut_fuse_reg <= `CSSC_SHIP_SUT;
        div8_fuse_reg <= `CSSC_SHIP_DIV8;
    end else if (state_reg == ST_LOAD) begin
        src_fuse_reg <= clock_source_select_fuses;
        sut_fuse_reg <= startup_delay_fuses;
        div8_fuse_reg <= divide_by_eight_fuse;
    end
end

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        state_reg <= ST_LOAD;
        cnt_reg <= {CNT_W{1'b0}};
    end else if (other_reset_active) begin
        state_reg <= ST_LOAD;
        cnt_reg <= {CNT_W{1'b0}};
    end else begin
        case (state_reg)
            ST_LOAD: begin
                state_reg <= ST_TOUT;
                cnt_reg <= tout_len(clock_source_select_fuses,
                    startup_delay_fuses);
            end
            ST_TOUT: begin
                if (cnt_reg == {CNT_W{1'b0}}) begin
                    state_reg <= ST_OSC;
                    cnt_reg <= osc_len(src_fuse_reg, sut_fuse_reg)
                        + `CSSC_OSC_RESET_EXTRA;
                end else if (wdt_osc_tick) begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
            ST_OSC, ST_WAKE: begin
                if (cnt_reg == {CNT_W{1'b0}}) begin
                    state_reg <= ST_RUN;
                end else if (osc_tick) begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
            ST_RUN: begin
                if (wake_from_sleep) begin
                    state_reg <= ST_WAKE;
                    cnt_reg <= osc_len(src_fuse_reg, sut_fuse_reg);
                end
            end
            default: begin
                state_reg <= ST_LOAD;
                cnt_reg <= {CNT_W{1'b0}};
            end
        endcase
    end
end

// ----------------------------------------------------------------
// outputs and clock routing
// ----------------------------------------------------------------
wire running = (state_reg == ST_RUN);
wire sys_tick_next = osc_tick &
    (div8_fuse_reg || (div_cnt_reg == `CSSC_DIV8_LAST));

always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
        internal_reset_n_reg <= 1'b0;
        startup_busy_reg <= 1'b1;
        source_class_reg <= {`CSSC_CLS_W{1'b0}};
        div_cnt_reg <= 3'h0;
        system_clock_tick_reg <= 1'b0;
        core_domain_clock <= 1'b0;
        peripheral_domain_clock <= 1'b0;
        flash_domain_clock <= 1'b0;
        async_timer_clock <= 1'b0;
        converter_domain_clock <= 1'b0;
    end else begin
        // reset held until both counts finish, not during wake
        internal_reset_n_reg <= ~(state_reg[0] | state_reg[1] |
            state_reg[2]) & ~other_reset_active;
        startup_busy_reg <= ~running;
        source_class_reg <= src_class(src_fuse_reg);
        if (osc_tick) begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
        system_clock_tick_reg <= sys_tick_next & running;
        core_domain_clock <= sys_tick_next & running &
            core_run_req;
        flash_domain_clock <= sys_tick_next & running &
            core_run_req;
        peripheral_domain_clock <= sys_tick_next & running &
            io_run_req;
        converter_domain_clock <= sys_tick_next & running &
            adc_run_req;
        async_timer_clock <= async_osc_tick & async_run_req &
            internal_reset_n_reg;
    end
end

endmodule

`default_nettype wire

// file: verification/cssc_osc_model.sv
// cssc_osc_model.sv: watchdog, selected and async oscillator tick source
// assumes ticks are one-cycle pulses on clk, changed 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module cssc_osc_model (
    // clock
    input wire logic clk,
    // oscillator ticks
    output logic wdt_osc_tick,
    output logic osc_tick,
    output logic async_osc_tick
);
    logic [1:0] phase_reg = 2'h0;
    // watchdog and selected ticks alternate, so phases never overlap
    always @(posedge clk) begin
        phase_reg <= #1 phase_reg + 2'h1;
    end
    assign wdt_osc_tick = ~phase_reg[0];
    assign osc_tick = phase_reg[0];
    assign async_osc_tick = &phase_reg;
endmodule
`default_nettype wire

// file: verification/cssc_startup_ctrl_monitor.sv
// cssc_startup_ctrl_monitor.sv: assertions on the start-up control ports
// assumes the cssc_startup_ctrl port list; attached by bind below
`include "cssc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cssc_startup_ctrl_monitor (
    // clock and reset
    input wire clk,
    input wire rstn,
    // inputs
    input wire divide_by_eight_fuse,
    input wire other_reset_active,
    input wire wake_from_sleep,
    input wire core_run_req,
    input wire io_run_req,
    input wire adc_run_req,
    input wire async_run_req,
    input wire async_osc_tick,
    // outputs
    input wire internal_reset_n_reg,
    input wire startup_busy_reg,
    input wire system_clock_tick_reg,
    input wire core_domain_clock,
    input wire peripheral_domain_clock,
    input wire flash_domain_clock,
    input wire async_timer_clock,
    input wire converter_domain_clock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    gated_in_reset_a: assert property (!internal_reset_n_reg |->
        !(system_clock_tick_reg || core_domain_clock)) else $error("tick");
    flash_follows_a: assert property (flash_domain_clock ==
        core_domain_clock) else $error("flash");
    core_gate_a: assert property (core_domain_clock ==
        (system_clock_tick_reg && $past(core_run_req))) else $error("core");
    io_gate_a: assert property (peripheral_domain_clock ==
        (system_clock_tick_reg && $past(io_run_req))) else $error("io");
    adc_gate_a: assert property (converter_domain_clock ==
        (system_clock_tick_reg && $past(adc_run_req))) else $error("adc");
    async_gate_a: assert property (async_timer_clock |->
        $past(async_osc_tick) && $past(async_run_req)) else $error("async");
    div8_gap_a: assert property (system_clock_tick_reg &&
        !divide_by_eight_fuse |=> !system_clock_tick_reg [*7])
        else $error("div8");
    other_reset_a: assert property (other_reset_active |->
        ##2 !internal_reset_n_reg) else $error("other reset");
    wake_keeps_a: assert property (wake_from_sleep &&
        internal_reset_n_reg && !startup_busy_reg && !other_reset_active
        |-> ##2 startup_busy_reg && internal_reset_n_reg) else $error("wake");
endmodule
bind cssc_startup_ctrl cssc_startup_ctrl_monitor u_mon (.clk, .rstn,
    .divide_by_eight_fuse, .other_reset_active, .wake_from_sleep,
    .core_run_req, .io_run_req, .adc_run_req, .async_run_req,
    .async_osc_tick, .internal_reset_n_reg, .startup_busy_reg,
    .system_clock_tick_reg, .core_domain_clock, .peripheral_domain_clock,
    .flash_domain_clock, .async_timer_clock, .converter_domain_clock);
`default_nettype wire

// file: verification/cssc_startup_ctrl_bench.sv
// cssc_startup_ctrl_bench.sv: self-checking bench for start-up control
// assumes cssc_osc_model supplies ticks; clk is 250 MHz
`timescale 1ns/1ps
`default_nettype none
module cssc_startup_ctrl_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] src = 4'h2;
    logic [1:0] sut = 2'h2;
    logic div8 = 1'b0;
    logic oth = 1'b0;
    logic wake = 1'b0;
    logic [3:0] req = 4'h0;
    wire wdt_t, osc_t, asy_t, rst_n, busy, sys, core, peri, asy, conv, flsh;
    wire [6:0] cls;
    int fails = 0;
    int check_count = 0;
    int n, tout, osc, e, cs, cc, cp, ca, cy, cf;
    initial forever #2 clk = ~clk;
    cssc_osc_model model (.clk, .wdt_osc_tick(wdt_t), .osc_tick(osc_t),
        .async_osc_tick(asy_t));
    cssc_startup_ctrl dut (.clk, .rstn, .clock_source_select_fuses(src),
        .startup_delay_fuses(sut), .divide_by_eight_fuse(div8),
        .other_reset_active(oth), .wake_from_sleep(wake),
        .wdt_osc_tick(wdt_t), .osc_tick(osc_t), .core_run_req(req[0]),
        .io_run_req(req[1]), .adc_run_req(req[2]), .async_run_req(req[3]),
        .async_osc_tick(asy_t), .internal_reset_n_reg(rst_n),
        .startup_busy_reg(busy), .source_class_reg(cls),
        .system_clock_tick_reg(sys), .core_domain_clock(core),
        .peripheral_domain_clock(peri), .flash_domain_clock(flsh),
        .async_timer_clock(asy), .converter_domain_clock(conv));
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input int lo, input int hi,
        input int got);
        check_count++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // expected time-out and start-up counts per fuse setting
    function automatic void counts(input int s, input int u);
        int i;
        i = (s % 2) * 4 + u;
        if (s >= 6) begin
            tout = (i % 3 == 0) ? 512 : (i % 3 == 1) ? 8192 : 0;
            osc = (i < 2) ? 258 : (i < 5) ? 1024 : 16384;
        end else begin
            tout = (u == 0) ? 0 : (u == 1) ? 512 : 8192;
            osc = (s == 4 || s == 5) ? 32768 : 6;
        end
    endfunction
    function automatic int cls_idx(input int s);
        return s >= 8 ? 0 : s >= 6 ? 1 : s >= 4 ? 2 : s == 3 ? 3 :
            s == 2 ? 4 : s == 0 ? 5 : 6;
    endfunction
    task automatic run_test(input int t, input logic [3:0] s,
        input logic [1:0] u, input logic d);
        // reset first, so the new fuse levels are only latched in ST_LOAD on release
        rstn = 1'b0;
        src = s;
        sut = u;
        div8 = d;
        counts(s, u);
        step(16);
        rstn = 1'b1;
        oth = 1'b1;
        step(4);
        oth = 1'b0;
        e = 2 * (tout + osc + 14);
        n = 0;
        while (rst_n !== 1'b1 && n < e + 20) begin
            step(1);
            n++;
        end
        chk("release", e, e + 8, n);
        check_count++;
        if (cls !== (7'h01 << cls_idx(s))) begin
            fails++;
            $display("[ERR] class expected %0d seen %h", cls_idx(s), cls);
        end
        req = $urandom;
        {cs, cc, cp, ca, cy, cf} = '0;
        step(1);
        repeat (160) begin
            step(1);
            cs += (sys === 1'b1);
            cc += (core === 1'b1);
            cp += (peri === 1'b1);
            ca += (conv === 1'b1);
            cy += (asy === 1'b1);
            cf += (flsh === 1'b1);
        end
        e = d ? 80 : 10;
        chk("sys ticks", e - 1, e + 1, cs);
        chk("core", req[0] ? cs : 0, req[0] ? cs : 0, cc);
        chk("flash", req[0] ? cs : 0, req[0] ? cs : 0, cf);
        chk("io", req[1] ? cs : 0, req[1] ? cs : 0, cp);
        chk("adc", req[2] ? cs : 0, req[2] ? cs : 0, ca);
        chk("async", req[3] ? 39 : 0, req[3] ? 41 : 0, cy);
        wake = 1'b1;
        step(1);
        wake = 1'b0;
        step(1);
        n = 0;
        while (busy !== 1'b0 && n < 2 * osc + 20) begin
            step(1);
            n++;
        end
        chk("wake", 2 * osc - 4, 2 * osc + 8, n);
        $display("test %0d done", t);
    endtask
    initial begin
        logic [3:0] rs;
        void'($urandom(32'h00619536));
        step(1);
        run_test(0, 4'h2, 2'h2, 1'b0);
        run_test(1, 4'h6, 2'h0, 1'b1);
        run_test(2, 4'h0, 2'h0, 1'b1);
        repeat (2) begin
            rs = $urandom;
            if (rs >= 4'h6) rs[0] = 1'b0;
            if (rs == 4'h4 || rs == 4'h5) rs = 4'h3;
            run_test(3, rs, $urandom, $urandom);
        end
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
